// file: thermal_fan_pkg.sv
package thermal_fan_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  // Ramp granularity: one duty step slot is this long per ramp second
  localparam int unsigned STEP_TIME_MS = 10;
  localparam int unsigned STEP_CYCLES  = CLK_HZ / 1000 * STEP_TIME_MS;

  ////////////////////////////////////////////////////////////////////////
  // Pulse generator
  localparam logic [31:0] PHASE_WRAP    = 32'h02fa_f080;
  localparam logic [31:0] SLOTS_PER_PER = 32'h0000_0064;
  localparam logic [6:0]  LAST_SLOT     = 7'h63;
  localparam logic [6:0]  DUTY_FULL     = 7'h64;
  localparam logic [6:0]  DUTY_RESET    = 7'h00;
  localparam logic [15:0] FREQ_3WIRE    = 16'h0064;
  localparam logic [15:0] FREQ_4WIRE    = 16'h4e20;

  ////////////////////////////////////////////////////////////////////////
  // Automatic control
  localparam logic [5:0]  RAMP_MAX_S    = 6'h32;
  localparam logic [3:0]  DIV_STEPS     = 4'hf;

  typedef enum logic [1:0] {
    LOAD_3WIRE   = 2'b00,
    LOAD_4WIRE   = 2'b01,
    LOAD_GENERIC = 2'b10
  } load_type_t;

  typedef enum logic [1:0] {
    BAND_OFF  = 2'b00,
    BAND_LOW  = 2'b01,
    BAND_FULL = 2'b10
  } band_t;

endpackage

// file: pwm_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pwm_if;
  logic [15:0] freq_hz;
  logic [6:0]  duty_pct;
  logic        pulse;

  modport ctrl (output freq_hz, output duty_pct, input pulse);
  modport gen  (input freq_hz, input duty_pct, output pulse);
endinterface

`default_nettype wire

// file: pwm_gen.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_gen (
  input  wire logic ref_clk,
  input  wire logic rst,
  pwm_if.gen        bus
);
  import thermal_fan_pkg::*;

  logic [31:0] phase_reg;
  logic [6:0]  slot_reg;
  logic [6:0]  duty_hold_reg;
  logic        pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // Hundred slots per period from a phase accumulator; avoids a divider
  wire logic [31:0] phase_step = 32'(bus.freq_hz) * SLOTS_PER_PER;
  wire logic [31:0] phase_sum  = phase_reg + phase_step;
  wire logic        slot_tick  = phase_sum >= PHASE_WRAP;
  wire logic [31:0] phase_next = slot_tick ? phase_sum - PHASE_WRAP
                                           : phase_sum;
  wire logic        period_end = slot_tick && (slot_reg == LAST_SLOT);
  wire logic [6:0]  slot_next  = period_end ? 7'h00 :
                                 slot_tick  ? slot_reg + 7'h01 : slot_reg;
  wire logic        duty_load  = period_end || (bus.freq_hz == 16'h0000);
  wire logic [6:0]  duty_next  = duty_load ? bus.duty_pct : duty_hold_reg;
  wire logic        pulse_next = slot_next < duty_next;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_reg     <= 32'h0000_0000;
      slot_reg      <= 7'h00;
      duty_hold_reg <= DUTY_RESET;
      pulse_reg     <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      slot_reg      <= slot_next;
      duty_hold_reg <= duty_next;
      pulse_reg     <= pulse_next;
    end
  end

  assign bus.pulse = pulse_reg;

endmodule // pwm_gen

`default_nettype wire

// file: thermal_fan_pwm_control.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Load type input selects three-wire fan, four-wire fan or generic load.
// - Auto enable picks temperature control; otherwise manual duty applies.
// - Auto mode, temperature above upper threshold gives full speed.
// - Auto mode, temperature below lower threshold and not above upper one turns the fan off.
// - Between thresholds the fan runs at the configured low-speed duty.
// - No low band unless lower threshold is strictly below upper one.
// - Hysteresis added to thresholds when rising, subtracted when falling.
// - Linear mode raises duty proportionally between the two thresholds.
// - Linear speed changes spread over 0 to 50 whole seconds.
// - Pulse frequency in hertz is configurable, typically 100 or 20000.
// - Manual mode holds the configured duty percentage of the period.
module thermal_fan_pwm_control #(
  parameter int unsigned STEP_CYCLES = thermal_fan_pkg::STEP_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic [1:0]                  load_type,
  input  wire logic                        auto_enable,
  input  wire logic [7:0]                  temperature,
  input  wire logic [7:0]                  full_speed_threshold,
  input  wire logic [7:0]                  fan_off_threshold,
  input  wire logic [7:0]                  hysteresis,
  input  wire logic                        linear_enable,
  input  wire logic [6:0]                  low_duty_pct,
  input  wire logic [5:0]                  ramp_seconds,
  input  wire logic [15:0]                 pwm_freq_hz,
  input  wire logic [6:0]                  manual_duty_pct,
  output wire logic                        fan_pulse_output,
  output logic [6:0]                       duty_status,
  output var thermal_fan_pkg::band_t       band_status
);
  import thermal_fan_pkg::*;

  pwm_if pwm ();

  ////////////////////////////////////////////////////////////////////////
  // Temperature direction and effective thresholds
  logic [7:0] prev_temp_reg;
  logic       rising_reg;

  wire logic [8:0] full_up   = {1'b0, full_speed_threshold} + {1'b0, hysteresis};
  wire logic [8:0] off_up    = {1'b0, fan_off_threshold} + {1'b0, hysteresis};
  wire logic [8:0] full_dn   = (full_speed_threshold > hysteresis) ?
                               {1'b0, full_speed_threshold - hysteresis} : 9'h000;
  wire logic [8:0] off_dn    = (fan_off_threshold > hysteresis) ?
                               {1'b0, fan_off_threshold - hysteresis} : 9'h000;
  wire logic [8:0] full_eff  = rising_reg ? full_up : full_dn;
  wire logic [8:0] off_eff   = rising_reg ? off_up : off_dn;
  wire logic       above_full = {1'b0, temperature} > full_eff;
  wire logic       below_off  = {1'b0, temperature} < off_eff;
  wire logic       band_ok   = fan_off_threshold < full_speed_threshold;

  // without a band, middle runs full as the safe choice
  wire band_t band_next = above_full ? BAND_FULL :
                          below_off  ? BAND_OFF  :
                          band_ok    ? BAND_LOW  : BAND_FULL;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_temp_reg <= 8'h00;
      rising_reg    <= 1'b1;
      band_status   <= BAND_OFF;
    end else begin
      prev_temp_reg <= temperature;
      if (temperature != prev_temp_reg) begin
        rising_reg <= temperature > prev_temp_reg;
      end
      band_status <= band_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Linear interpolation: serial divider, restarts continuously
  logic [3:0]  div_cnt_reg;
  logic [14:0] num_reg;
  logic [7:0]  den_reg;
  logic [8:0]  rem_reg;
  logic [14:0] quo_reg;
  logic [6:0]  lin_frac_reg;

  wire logic [6:0]  low_clamped = (low_duty_pct > DUTY_FULL) ? DUTY_FULL
                                                              : low_duty_pct;
  wire logic [6:0]  span        = DUTY_FULL - low_clamped;
  wire logic [7:0]  band_width  = full_speed_threshold - fan_off_threshold;
  wire logic [7:0]  t_rel       =
    (temperature <= fan_off_threshold)    ? 8'h00 :
    (temperature >= full_speed_threshold) ? band_width :
    temperature - fan_off_threshold;
  wire logic [14:0] num_start   = 15'({8'h00, span} * {7'h00, t_rel});
  wire logic [8:0]  rem_sh      = {rem_reg[7:0], num_reg[14]};
  wire logic [9:0]  trial       = {1'b0, rem_sh} - {2'b00, den_reg};
  wire logic        fits        = !trial[9];
  wire logic        div_done    = div_cnt_reg == DIV_STEPS;
  // Last quotient bit is shifted in on the done cycle itself
  wire logic [14:0] quo_all     = {quo_reg[13:0], fits};
  // Quotient exceeds span only without a band; when it does not fit seven bits it is replaced by span
  wire logic [6:0]  quo_final   = (quo_all[14:7] != 8'h00) ? span
                                                           : quo_all[6:0];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_cnt_reg  <= 4'h0;
      num_reg      <= 15'h0000;
      den_reg      <= 8'h00;
      rem_reg      <= 9'h000;
      quo_reg      <= 15'h0000;
      lin_frac_reg <= 7'h00;
    end else if (div_cnt_reg == 4'h0) begin
      num_reg     <= num_start;
      den_reg     <= band_ok ? band_width : 8'h01;
      rem_reg     <= 9'h000;
      quo_reg     <= 15'h0000;
      div_cnt_reg <= 4'h1;
    end else begin
      num_reg <= {num_reg[13:0], 1'b0};
      rem_reg <= fits ? trial[8:0] : rem_sh;
      quo_reg <= {quo_reg[13:0], fits};
      div_cnt_reg <= div_done ? 4'h0 : div_cnt_reg + 4'h1;
      if (div_done) begin
        lin_frac_reg <= quo_final;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target duty selection
  // proportional duty in band
  wire logic [6:0] lin_duty    = low_clamped + lin_frac_reg;
  wire logic [6:0] band_duty   = linear_enable ? lin_duty : low_clamped;
  wire logic [6:0] auto_duty   = (band_status == BAND_FULL) ? DUTY_FULL :
                                 (band_status == BAND_LOW)  ? band_duty :
                                 7'h00;
  wire logic [6:0] manual_duty = (manual_duty_pct > DUTY_FULL) ? DUTY_FULL
                                                               : manual_duty_pct;
  wire logic [15:0] type_freq  =
    (load_type == LOAD_3WIRE) ? FREQ_3WIRE :
    (load_type == LOAD_4WIRE) ? FREQ_4WIRE : 16'h0000;
  wire logic [15:0] eff_freq   = (pwm_freq_hz != 16'h0000) ? pwm_freq_hz
                                                           : type_freq;
  wire logic [6:0] target_duty = (eff_freq == 16'h0000) ? 7'h00 :
                                 auto_enable ? auto_duty : manual_duty;

  ////////////////////////////////////////////////////////////////////////
  // Timed ramp: one percent per ramp_seconds * 10 ms, so 100 % in ramp_seconds
  logic [19:0] tick_cnt_reg;
  logic [5:0]  sec_cnt_reg;

  wire logic [5:0] ramp_s      = (ramp_seconds > RAMP_MAX_S) ? RAMP_MAX_S
                                                             : ramp_seconds;
  wire logic       ramp_active = auto_enable && linear_enable &&
                                 (ramp_s != 6'h00) && (eff_freq != 16'h0000);
  wire logic       tick        = tick_cnt_reg == 20'(STEP_CYCLES - 1);
  wire logic       step        = tick && (sec_cnt_reg >= ramp_s - 6'h01);
  wire logic [6:0] ramp_duty   =
    (duty_status < target_duty) ? duty_status + 7'h01 :
    (duty_status > target_duty) ? duty_status - 7'h01 : duty_status;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tick_cnt_reg <= 20'h00000;
      sec_cnt_reg  <= 6'h00;
      duty_status  <= DUTY_RESET;
    end else begin
      tick_cnt_reg <= tick ? 20'h00000 : tick_cnt_reg + 20'h00001;
      if (step || !ramp_active) begin
        sec_cnt_reg <= 6'h00;
      end else if (tick) begin
        sec_cnt_reg <= sec_cnt_reg + 6'h01;
      end
      if (!ramp_active) begin
        duty_status <= target_duty;
      end else if (step) begin
        duty_status <= ramp_duty;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pulse generation
  assign pwm.freq_hz  = eff_freq;
  assign pwm.duty_pct = duty_status;

  pwm_gen u_pwm_gen (
    .ref_clk (ref_clk),
    .rst     (rst),
    .bus     (pwm.gen)
  );

  assign fan_pulse_output = pwm.pulse;

endmodule // thermal_fan_pwm_control

`default_nettype wire

// file: thermal_fan_pwm_control_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_fan_pwm_control_asserts #(
  parameter int unsigned STEP_CYCLES = 20
) (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic                   auto_enable,
  input wire logic [7:0]             temperature,
  input wire logic [7:0]             full_speed_threshold,
  input wire logic [7:0]             fan_off_threshold,
  input wire logic [7:0]             hysteresis,
  input wire logic                   linear_enable,
  input wire logic [6:0]             low_duty_pct,
  input wire logic [15:0]            pwm_freq_hz,
  input wire logic [6:0]             manual_duty_pct,
  input wire logic [6:0]             duty_status,
  input wire thermal_fan_pkg::band_t band_status
);
  import thermal_fan_pkg::*;
  logic [8:0] full_hi, off_hi, t_hi;
  // Bounds widened by hysteresis hold whichever way it is applied
  assign full_hi = {1'b0, full_speed_threshold} + {1'b0, hysteresis};
  assign off_hi  = {1'b0, fan_off_threshold} + {1'b0, hysteresis};
  assign t_hi    = {1'b0, temperature} + {1'b0, hysteresis};
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence band_held(band_t b);
    auto_enable && !linear_enable && pwm_freq_hz != 16'h0000 &&
      band_status == b && $stable(band_status);
  endsequence
  AST_BAND_FULL: assert property (
    auto_enable && fan_off_threshold < full_speed_threshold &&
    {1'b0, temperature} > full_hi |=> band_status == BAND_FULL) else $error("no full band");
  AST_BAND_OFF: assert property (
    auto_enable && fan_off_threshold < full_speed_threshold &&
    t_hi < {1'b0, fan_off_threshold} |=> band_status == BAND_OFF) else $error("no off band");
  AST_BAND_LOW: assert property (
    auto_enable && {1'b0, temperature} > off_hi &&
    t_hi < {1'b0, full_speed_threshold} |=> band_status == BAND_LOW) else $error("no low band");
  AST_NO_LOW: assert property (
    auto_enable && fan_off_threshold >= full_speed_threshold
    |=> band_status != BAND_LOW) else $error("low band unordered");
  AST_FULL_DUTY: assert property (
    band_held(BAND_FULL) [*4] |-> duty_status == DUTY_FULL)
    else $error("full band duty wrong");
  AST_OFF_DUTY: assert property (
    band_held(BAND_OFF) [*4] |-> duty_status == DUTY_RESET)
    else $error("off band duty wrong");
  AST_LOW_DUTY: assert property (
    band_held(BAND_LOW) [*4] ##0 low_duty_pct <= DUTY_FULL
    |-> duty_status == low_duty_pct) else $error("low band duty wrong");
  AST_MANUAL_DUTY: assert property (
    (!auto_enable && pwm_freq_hz != 16'h0000 && $stable(manual_duty_pct) &&
     manual_duty_pct <= DUTY_FULL) [*4] |-> duty_status == manual_duty_pct)
    else $error("manual duty wrong");
endmodule // thermal_fan_pwm_control_asserts
////////////////////////////////////////////////////////////////////////////
bind thermal_fan_pwm_control thermal_fan_pwm_control_asserts #(
  .STEP_CYCLES(STEP_CYCLES)
) chk (.ref_clk(ref_clk), .rst(rst), .auto_enable(auto_enable),
  .temperature(temperature), .full_speed_threshold(full_speed_threshold),
  .fan_off_threshold(fan_off_threshold), .hysteresis(hysteresis),
  .linear_enable(linear_enable), .low_duty_pct(low_duty_pct),
  .pwm_freq_hz(pwm_freq_hz), .manual_duty_pct(manual_duty_pct),
  .duty_status(duty_status), .band_status(band_status));
`default_nettype wire

// file: fan_load.sv
`timescale 1ns/1ps
`default_nettype none
module fan_load (
  input  wire logic        ref_clk,
  input  wire logic        clr,
  input  wire logic        fan_pulse_output,
  output logic      [11:0] on_cycles
);
  // Drive time seen by the load since clear; window of 4095 at most
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      on_cycles <= 12'h000;
    end else begin
      on_cycles <= on_cycles + {11'h000, fan_pulse_output};
    end
  end
endmodule // fan_load
`default_nettype wire

// file: test_thermal_fan_pwm_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    bad_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module test_thermal_fan_pwm_control;
  import thermal_fan_pkg::*;
  logic        ref_clk, rst, auto_enable, linear_enable, clr;
  logic        fan_pulse_output;
  logic [1:0]  load_type;
  logic [7:0]  temperature, full_speed_threshold, fan_off_threshold;
  logic [7:0]  hysteresis;
  logic [6:0]  low_duty_pct, manual_duty_pct, duty_status;
  logic [5:0]  ramp_seconds;
  logic [15:0] pwm_freq_hz;
  logic [11:0] on_cycles;
  band_t       band_status;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [6:0]  duty_tab [3] = '{7'h00, 7'h1e, 7'h64};
  thermal_fan_pwm_control #(.STEP_CYCLES(20)) dut (
    .ref_clk(ref_clk), .rst(rst), .load_type(load_type),
    .auto_enable(auto_enable), .temperature(temperature),
    .full_speed_threshold(full_speed_threshold),
    .fan_off_threshold(fan_off_threshold), .hysteresis(hysteresis),
    .linear_enable(linear_enable), .low_duty_pct(low_duty_pct),
    .ramp_seconds(ramp_seconds), .pwm_freq_hz(pwm_freq_hz),
    .manual_duty_pct(manual_duty_pct), .fan_pulse_output(fan_pulse_output),
    .duty_status(duty_status), .band_status(band_status));
  fan_load load (.ref_clk(ref_clk), .clr(clr),
    .fan_pulse_output(fan_pulse_output), .on_cycles(on_cycles));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Run is about 20000 cycles long
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic put_temp(logic [7:0] t);
    temperature = t;
    step(3);
  endtask
  // Window equal to whole periods, so phase does not matter
  task automatic read_on(int win, logic [11:0] ex);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(win);
    `CHK("on_cycles", ex, on_cycles)
  endtask
  initial begin
    rst = 1'b1; clr = 1'b0; load_type = 2'b01; auto_enable = 1'b0;
    temperature = 8'h14; full_speed_threshold = 8'h46;
    fan_off_threshold = 8'h28; hysteresis = 8'h02; linear_enable = 1'b0;
    low_duty_pct = 7'h28; ramp_seconds = 6'h00; pwm_freq_hz = 16'hc350;
    manual_duty_pct = 7'h1e;
    step(16);
    `CHK("reset duty", DUTY_RESET, duty_status)
    rst = 1'b0;
    foreach (duty_tab[i]) begin
      manual_duty_pct = duty_tab[i];
      step(1200);
      `CHK("duty_status", duty_tab[i], duty_status)
      read_on(1000, {5'h00, duty_tab[i]} * 12'h00a);
    end
    manual_duty_pct = 7'h1e;
    pwm_freq_hz = 16'h61a8;
    step(2200);
    read_on(2000, 12'h258);
    pwm_freq_hz = 16'hc350;
    auto_enable = 1'b1;
    put_temp(8'h14);
    `CHK("band", BAND_OFF, band_status)
    put_temp(8'h37);
    `CHK("band", BAND_LOW, band_status)
    step(1200);
    read_on(1000, 12'h190);
    put_temp(8'h47);
    `CHK("band", BAND_LOW, band_status)
    put_temp(8'h50);
    step(3);
    `CHK("duty_status", DUTY_FULL, duty_status)
    put_temp(8'h45);
    `CHK("band", BAND_FULL, band_status)
    fan_off_threshold = 8'h46;
    full_speed_threshold = 8'h28;
    put_temp(8'h37);
    `CHK("low band", 1'b0, band_status == BAND_LOW)
    fan_off_threshold = 8'h28;
    full_speed_threshold = 8'h46;
    hysteresis = 8'h00;
    put_temp(8'h14);
    linear_enable = 1'b1;
    put_temp(8'h37);
    step(60);
    `CHK("linear duty", 7'h46, duty_status)
    ramp_seconds = 6'h01;
    put_temp(8'h14);
    step(200);
    `CHK("ramp", 1'b1, duty_status > 7'h38 && duty_status < 7'h42)
    step(1500);
    `CHK("ramp end", DUTY_RESET, duty_status)
    auto_enable = 1'b0;
    linear_enable = 1'b0;
    load_type = 2'b10;
    pwm_freq_hz = 16'h0000;
    step(50);
    `CHK("generic duty", DUTY_RESET, duty_status)
    read_on(200, 12'h000);
    load_type = 2'b01;
    manual_duty_pct = 7'h1e;
    step(2600);
    read_on(2500, 12'h2ee);
    test_done();
  end
endmodule // test_thermal_fan_pwm_control
`default_nettype wire
